// [design/cml_regs.svh]
// constants for the configuration and mode latch bank
// assumes inclusion by bare name from design and bench files
`ifndef CML_REGS_SVH
`define CML_REGS_SVH

// ====================================================
// command byte layout
`define CML_CMD_W        8
`define CML_CMD_VAL_BIT  7
`define CML_CMD_ADDR_MSB 6
`define CML_CMD_ADDR_LSB 1
`define CML_ADDR_W       6

// ====================================================
// latch map
`define CML_CFG_COUNT    56
`define CML_MODE_BASE    6'h38
`define CML_MODE_COUNT   8
`define CML_GAIN_LSB     40
`define CML_GAIN_W       8
`define CML_OSC_LSB      48
`define CML_OSC_W        2
`define CML_TAMPER_BIT   53
`define CML_MODE_BANK    0
`define CML_MODE_CHAN_SEL 4
`define CML_MODE_SWAP    7
`define CML_OSC_CODE_UP  2'h1
`define CML_OSC_CODE_DN  2'h2

// ====================================================
// read burst
`define CML_RECORDS      8
`define CML_REC_W        3
`define CML_REC_HALF     3'h4
`define CML_RECORD_W     32

`endif

// [design/cml_pkg.sv]
// types shared by the latch bank and its record sequencer
// assumes nothing beyond a SystemVerilog compiler
package cml_pkg;
  // ====================================================
  // oscillator correction as seen by the clock generator
  typedef enum logic [1:0] {CML_OSC_NONE, CML_OSC_RAISE, CML_OSC_LOWER} cml_osc_type;
  // read burst sequencer states
  typedef enum logic {CML_SEQ_IDLE, CML_SEQ_READ} cml_seq_type;
endpackage

// [design/cml_record_order.sv]
// record order sequencer for one read burst
// assumes strobes are one-cycle pulses synchronous to clk_i
`timescale 1ns/1ps
`include "cml_regs.svh"

module cml_record_order
  import cml_pkg::*;
#(
  parameter int RECORDS = `CML_RECORDS
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  swap_req_i,
  input  wire logic                  read_start_i,
  input  wire logic                  read_abort_i,
  input  wire logic                  record_adv_i,
  output logic                       reading_o,
  output logic                       swap_pending_o,
  output logic [`CML_REC_W-1:0]      record_index_o
);
  // ====================================================
  // elaboration check
  if (RECORDS != `CML_RECORDS) begin : g_bad_records
    $error("record count must equal the eight-record burst");
  end

  // ====================================================
  // state
  cml_seq_type             state_reg, state_next;
  logic [`CML_REC_W-1:0]   count_reg, count_next;
  logic                    pend_reg, pend_next;
  logic                    swap_reg, swap_next;
  wire                     last_rec = (count_reg == `CML_REC_W'(RECORDS - 1));

  // next state: a start takes the pending swap and consumes it
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    swap_next  = swap_reg;
    pend_next  = pend_reg | swap_req_i;
    unique case (state_reg)
      CML_SEQ_IDLE: begin
        if (read_start_i) begin
          state_next = CML_SEQ_READ;
          count_next = '0;
          swap_next  = pend_reg;
          pend_next  = swap_req_i;
        end
      end
      CML_SEQ_READ: begin
        if (read_abort_i) begin
          state_next = CML_SEQ_IDLE;
        end else if (record_adv_i) begin
          count_next = count_reg + 1'b1;
          if (last_rec) begin
            state_next = CML_SEQ_IDLE;
          end
        end
      end
    endcase
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= CML_SEQ_IDLE;
      count_reg <= '0;
      pend_reg  <= 1'b0;
      swap_reg  <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      count_reg <= count_next;
      pend_reg  <= pend_next;
      swap_reg  <= swap_next;
    end
  end

  // swapped order flips the half: 5..8 then 1..4
  assign record_index_o = swap_reg ? (count_reg ^ `CML_REC_HALF) : count_reg;
  assign reading_o      = (state_reg == CML_SEQ_READ);
  assign swap_pending_o = pend_reg;

  // ====================================================
  // checks
  sequence s_start_swapped;
    ce_i && read_start_i && state_reg == CML_SEQ_IDLE && pend_reg;
  endsequence

  chk_swap_first_rec : assert property (@(posedge clk_i) disable iff (rst_i)
    s_start_swapped |=> record_index_o == `CML_REC_HALF)
    else $error("swapped burst does not open with record five");

  chk_swap_consumed : assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && read_start_i && state_reg == CML_SEQ_IDLE && !swap_req_i) |=> !pend_reg)
    else $error("swap request survived a read start");

  chk_plain_order : assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && read_start_i && state_reg == CML_SEQ_IDLE && !pend_reg)
      |=> record_index_o == '0 && reading_o)
    else $error("plain burst does not open with record one");

  chk_burst_ends : assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reading_o && record_adv_i && !read_abort_i && last_rec) |=> !reading_o)
    else $error("burst runs past eight records");
endmodule

// [design/cml_latch_bank.sv]
// configuration and mode latch bank written by single-bit command bytes
// assumes the serial shifter delivers whole bytes with a one-cycle strobe
`timescale 1ns/1ps
`include "cml_regs.svh"

// What this block does
// - Latches 40 to 47 hold an unsigned gain trim for the secondary current channel.
// - Latches 48 and 49 hold the oscillator trim: 1 raises, 2 lowers, 0 and 3 do nothing.
// - Latch 53 picks the tamper threshold, 0 the coarse and 1 the fine one.
// - There are exactly 56 configuration latches, each set by its own command.
// - Power-on reset clears the configuration latches and a remote reset leaves them.
// - Seven mode signals (bits 0 to 6) are kept and shown in one 32-bit record word; bit 7 reads zero.
// - Power-on reset clears the mode signals and a remote reset leaves them.
// - Mode signals are written with the same command byte format as configuration.
// - Mode bit 0 is the oscillator start-up bank and drives that path when set.
// - Mode bit 4 routes current channel 2 instead of 1 while tamper detection is off.
// - With tamper off and the select bit clear, channel 1 is the current source.
// - Command for mode bit 7 reorders the next burst to records 5 to 8 then 1 to 4.
// - The reorder is used once and must be sent again before each burst.
// - A command byte is value bit, six address bits, then a don't-care bit.
// - A read burst offers up to eight 32-bit records in sequence.
module cml_latch_bank
  import cml_pkg::*;
#(
  parameter int CFG_COUNT = `CML_CFG_COUNT
) (
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_I,
  input  wire logic                       CE_I,
  input  wire logic [`CML_CMD_W-1:0]      CMD_BYTE_I,
  input  wire logic                       CMD_VALID_I,
  input  wire logic                       REMOTE_RESET_REQUEST_I,
  input  wire logic                       TAMPER_ENABLE_I,
  input  wire logic                       READ_START_I,
  input  wire logic                       READ_ABORT_I,
  input  wire logic                       RECORD_ADV_I,
  output logic [`CML_CFG_COUNT-1:0]       CONFIG_BITS_O,
  output logic [`CML_GAIN_W-1:0]          SECONDARY_CURRENT_GAIN_TRIM_O,
  output logic [`CML_OSC_W-1:0]           RC_OSCILLATOR_TRIM_O,
  output cml_osc_type                     OSC_CORRECTION_O,
  output logic                            TAMPER_THRESHOLD_SELECT_O,
  output logic [`CML_MODE_COUNT-1:0]      OPERATING_MODE_FLAGS_O,
  output logic [`CML_RECORD_W-1:0]        MODE_RECORD_O,
  output logic                            RC_START_BANK_O,
  output logic                            CURRENT_CHANNEL_SELECT_O,
  output logic                            CURRENT_CH2_ROUTED_O,
  output logic                            READING_O,
  output logic [`CML_REC_W-1:0]           RECORD_INDEX_O
);
  // ====================================================
  // elaboration check
  if (CFG_COUNT != `CML_CFG_COUNT) begin : g_bad_cfg
    $error("configuration latch count must be fifty-six");
  end

  // ====================================================
  // command decode
  wire                     cmd_take = CMD_VALID_I && CE_I;
  wire                     cmd_val  = CMD_BYTE_I[`CML_CMD_VAL_BIT];
  wire [`CML_ADDR_W-1:0]   cmd_addr = CMD_BYTE_I[`CML_CMD_ADDR_MSB:`CML_CMD_ADDR_LSB];
  wire                     is_mode  = (cmd_addr >= `CML_MODE_BASE);
  wire [`CML_REC_W-1:0]    mode_idx = cmd_addr[`CML_REC_W-1:0];
  // bit 7 is a one-shot request, never stored
  wire                     swap_req = cmd_take && is_mode && cmd_val
                                      && (mode_idx == `CML_REC_W'(`CML_MODE_SWAP));

  // ====================================================
  // configuration latches: one per address, cleared only by power-on
  logic [`CML_CFG_COUNT-1:0] cfg_reg;

  for (genvar i = 0; i < `CML_CFG_COUNT; i++) begin : g_cfg
    wire hit = cmd_take && !is_mode && (cmd_addr == `CML_ADDR_W'(i));
    // remote reset deliberately has no path into these flops
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        cfg_reg[i] <= 1'b0;
      end else if (hit) begin
        cfg_reg[i] <= cmd_val;
      end
    end
  end

  // ====================================================
  // mode latches 0..6, same byte format; 7 is one-shot
  logic [`CML_MODE_COUNT-1:0] mode_reg;

  for (genvar k = 0; k < `CML_MODE_COUNT; k++) begin : g_mode
    if (k == `CML_MODE_SWAP) begin : g_swap
      assign mode_reg[k] = 1'b0;
    end else begin : g_kept
      wire hit = cmd_take && is_mode && (mode_idx == `CML_REC_W'(k));
      always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          mode_reg[k] <= 1'b0;
        end else if (hit) begin
          mode_reg[k] <= cmd_val;
        end
      end
    end
  end

  // ====================================================
  // field views of the latches
  assign CONFIG_BITS_O                 = cfg_reg;
  assign SECONDARY_CURRENT_GAIN_TRIM_O = cfg_reg[`CML_GAIN_LSB +: `CML_GAIN_W];
  assign RC_OSCILLATOR_TRIM_O          = cfg_reg[`CML_OSC_LSB +: `CML_OSC_W];
  assign TAMPER_THRESHOLD_SELECT_O     = cfg_reg[`CML_TAMPER_BIT];

  // oscillator correction decode, codes 0 and 3 mean none
  assign OSC_CORRECTION_O =
    (RC_OSCILLATOR_TRIM_O == `CML_OSC_CODE_UP) ? CML_OSC_RAISE :
    (RC_OSCILLATOR_TRIM_O == `CML_OSC_CODE_DN) ? CML_OSC_LOWER : CML_OSC_NONE;

  // mode views and the readable record word
  assign OPERATING_MODE_FLAGS_O   = mode_reg;
  assign MODE_RECORD_O            = {{(`CML_RECORD_W - `CML_MODE_COUNT){1'b0}}, mode_reg};
  assign RC_START_BANK_O          = mode_reg[`CML_MODE_BANK];
  assign CURRENT_CHANNEL_SELECT_O = mode_reg[`CML_MODE_CHAN_SEL];
  // channel 2 only with tamper off and select set, else channel 1
  assign CURRENT_CH2_ROUTED_O     = !TAMPER_ENABLE_I && mode_reg[`CML_MODE_CHAN_SEL];

  // ====================================================
  // read order sequencer
  cml_record_order #(
    .RECORDS        (`CML_RECORDS)
  ) u_order (
    .clk_i          (CORE_CLK_I),
    .rst_i          (RST_I),
    .ce_i           (CE_I),
    .swap_req_i     (swap_req),
    .read_start_i   (READ_START_I),
    .read_abort_i   (READ_ABORT_I),
    .record_adv_i   (RECORD_ADV_I),
    .reading_o      (READING_O),
    .swap_pending_o (),
    .record_index_o (RECORD_INDEX_O)
  );

  // ====================================================
  // checks
  sequence s_cfg_write;
    cmd_take && !is_mode;
  endsequence

  chk_cfg_write_lands : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    s_cfg_write |=> cfg_reg[$past(cmd_addr)] == $past(cmd_val))
    else $error("configuration latch missed its write");

  chk_cfg_remote_keep : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (REMOTE_RESET_REQUEST_I && !cmd_take) |=> $stable(cfg_reg))
    else $error("remote reset disturbed configuration latches");

  chk_mode_remote_keep : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (REMOTE_RESET_REQUEST_I && !cmd_take) |=> $stable(mode_reg))
    else $error("remote reset disturbed mode latches");

  chk_bank_set : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && CMD_BYTE_I[`CML_CMD_W-1:1] == 7'h78) |=> RC_START_BANK_O)
    else $error("start-up bank not set by its command");

  chk_chan_sel_clear : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && CMD_BYTE_I[`CML_CMD_W-1:1] == 7'h3C) |=> !CURRENT_CHANNEL_SELECT_O)
    else $error("channel select not cleared by its command");

  chk_ch1_default : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (!TAMPER_ENABLE_I && !CURRENT_CHANNEL_SELECT_O) |-> !CURRENT_CH2_ROUTED_O)
    else $error("channel 2 routed without its select");

  chk_osc_raise : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cfg_reg[`CML_OSC_LSB] && !cfg_reg[`CML_OSC_LSB + 1]) |-> OSC_CORRECTION_O == CML_OSC_RAISE)
    else $error("oscillator trim code one not decoded");

  chk_swap_unstored : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    swap_req |=> MODE_RECORD_O[`CML_MODE_SWAP] == 1'b0)
    else $error("read-order swap was stored as a mode flag");

  chk_record_upper_zero : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    MODE_RECORD_O[`CML_RECORD_W-1:`CML_MODE_COUNT] == '0)
    else $error("mode record carries bits above the flags");

  // field level checks: writes land in their fields, and decodes and routing follow the latches
  chk_gain_write_lands : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && !is_mode && cmd_addr >= `CML_GAIN_LSB
      && cmd_addr < `CML_GAIN_LSB + `CML_GAIN_W)
      |=> SECONDARY_CURRENT_GAIN_TRIM_O[$past(cmd_addr) - `CML_GAIN_LSB]
          == $past(cmd_val))
    else $error("gain trim bit missed its write");

  chk_osc_lower : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (!cfg_reg[`CML_OSC_LSB] && cfg_reg[`CML_OSC_LSB + 1])
      |-> OSC_CORRECTION_O == CML_OSC_LOWER)
    else $error("oscillator trim code two not decoded");

  chk_osc_none : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cfg_reg[`CML_OSC_LSB] == cfg_reg[`CML_OSC_LSB + 1])
      |-> OSC_CORRECTION_O == CML_OSC_NONE)
    else $error("oscillator trim codes zero and three must not correct");

  chk_tamper_write : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && !is_mode && cmd_addr == `CML_ADDR_W'(`CML_TAMPER_BIT))
      |=> TAMPER_THRESHOLD_SELECT_O == $past(cmd_val))
    else $error("tamper threshold select missed its write");

  chk_bank_clear : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && CMD_BYTE_I[`CML_CMD_W-1:1] == 7'h38) |=> !RC_START_BANK_O)
    else $error("start-up bank not cleared by its command");

  chk_chan_sel_set : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && CMD_BYTE_I[`CML_CMD_W-1:1] == 7'h7C) |=> CURRENT_CHANNEL_SELECT_O)
    else $error("channel select not set by its command");

  chk_ch2_route : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (!TAMPER_ENABLE_I && CURRENT_CHANNEL_SELECT_O) |-> CURRENT_CH2_ROUTED_O)
    else $error("channel 2 not routed with tamper off and select set");

  chk_tamper_ch1 : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    TAMPER_ENABLE_I |-> !CURRENT_CH2_ROUTED_O)
    else $error("channel 2 routed while tamper detection is active");

  chk_mode_write_lands : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && is_mode && mode_idx != `CML_REC_W'(`CML_MODE_SWAP))
      |=> mode_reg[$past(mode_idx)] == $past(cmd_val))
    else $error("mode latch missed its write");

  // reserved configuration writes at 50 to 52, 54 and 55 are stored but must leave every field view alone
  chk_reserved_quiet : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cmd_take && !is_mode && cmd_addr >= `CML_OSC_LSB + `CML_OSC_W
      && cmd_addr != `CML_ADDR_W'(`CML_TAMPER_BIT))
      |=> $stable(SECONDARY_CURRENT_GAIN_TRIM_O) && $stable(RC_OSCILLATOR_TRIM_O)
          && $stable(TAMPER_THRESHOLD_SELECT_O))
    else $error("reserved write changed a field");

  chk_cmd_gated : assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (CMD_VALID_I && !CE_I) |=> $stable(cfg_reg) && $stable(mode_reg))
    else $error("command taken while the clock enable was low");
endmodule

// [verification/cml_host_model.sv]
// host side model that sends single-bit write command bytes
// assumes every call begins at a falling edge of clk_i
`timescale 1ns/1ps

module cml_host_model (
  input  wire logic       clk_i,
  output logic [7:0]      cmd_byte_o,
  output logic            cmd_valid_o
);
  // ==================================================
  // command byte driver
  initial begin
    cmd_byte_o  = 8'h00;
    cmd_valid_o = 1'b0;
  end

  // value first, six address bits, then the don't-care bit; mode bits alike
  task automatic send(input logic val, input logic [5:0] addr, input logic dc);
    cmd_byte_o  = {val, addr, dc};
    cmd_valid_o = 1'b1;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o  = ~cmd_byte_o; // a released byte must not look still valid
    @(negedge clk_i); // idle cycle, so a following call never re-raises valid at once
  endtask
endmodule

// [verification/config_mode_latch_bank_bench.sv]
// self-checking bench for the configuration and mode latch bank
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`include "cml_regs.svh"

module config_mode_latch_bank_bench;
  import cml_pkg::*;
  // ==================================================
  // stimulus, outputs and expected state
  logic         core_clk = 1'b0, rst = 1'b1, ce = 1'b1, remote_reset = 1'b0, tamper = 1'b0;
  logic         start = 1'b0, abort = 1'b0, adv = 1'b0, probe = 1'b0;
  logic [7:0]   cmd_byte, mode_flags, gain;
  logic         cmd_valid, thr, bank, chan_sel, ch2, reading;
  logic [55:0]  cfg_bits, exp_cfg = '0;
  logic [31:0]  mode_rec;
  logic [1:0]   osc_trim;
  cml_osc_type  osc_corr;
  logic [2:0]   rec_idx;
  logic [7:0]   exp_mode = '0;
  logic         exp_swap = 1'b0;
  logic [115:0] seen;
  logic [115:0] notes[$];
  int           num_errors = 0, check_count = 0, cycles = 0;
  integer       seed = 32'ha438dad8;

  always #4 core_clk = ~core_clk;

  cml_host_model host_inst (.clk_i(core_clk), .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid));

  cml_latch_bank cml_latch_bank_inst (
    .CORE_CLK_I(core_clk), .RST_I(rst), .CE_I(ce), .CMD_BYTE_I(cmd_byte),
    .CMD_VALID_I(cmd_valid), .REMOTE_RESET_REQUEST_I(remote_reset), .TAMPER_ENABLE_I(tamper),
    .READ_START_I(start), .READ_ABORT_I(abort), .RECORD_ADV_I(adv),
    .CONFIG_BITS_O(cfg_bits), .SECONDARY_CURRENT_GAIN_TRIM_O(gain),
    .RC_OSCILLATOR_TRIM_O(osc_trim), .OSC_CORRECTION_O(osc_corr),
    .TAMPER_THRESHOLD_SELECT_O(thr), .OPERATING_MODE_FLAGS_O(mode_flags),
    .MODE_RECORD_O(mode_rec), .RC_START_BANK_O(bank), .CURRENT_CHANNEL_SELECT_O(chan_sel),
    .CURRENT_CH2_ROUTED_O(ch2), .READING_O(reading), .RECORD_INDEX_O(rec_idx));

  // all outputs in one word; record index only matters while reading
  assign seen = {cfg_bits, mode_flags, mode_rec, gain, osc_trim, osc_corr, thr, bank,
                 chan_sel, ch2, reading, rec_idx & {3{reading}}};

  // ==================================================
  // expected outputs worked out from the bench's own state
  function automatic logic [115:0] view(input logic rd, input logic [2:0] idx);
    logic [1:0] c;
    c = (exp_cfg[49:48] == 2'h1) ? 2'h1 : ((exp_cfg[49:48] == 2'h2) ? 2'h2 : 2'h0);
    return {exp_cfg, exp_mode, 24'h0, exp_mode, exp_cfg[47:40], exp_cfg[49:48], c,
            exp_cfg[53], exp_mode[0], exp_mode[4], ~tamper & exp_mode[4], rd, idx};
  endfunction

  task automatic compare(input logic [115:0] s, input logic [115:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // note the expectation, then let the watcher sample at the next rising edge
  task automatic check_now(input logic rd, input logic [2:0] idx);
    notes.push_back(view(rd, idx));
    probe = 1'b1;
    @(negedge core_clk);
    probe = 1'b0;
  endtask

  // watcher takes the oldest note whenever a probe is up
  always @(posedge core_clk) begin
    if (probe) begin
      compare(seen, notes.pop_front());
    end
  end

  // one write through the host model, mirrored in the expected state
  task automatic put(input logic val, input logic [5:0] addr);
    host_inst.send(val, addr, 1'($random(seed)));
    if (addr < 6'd56) exp_cfg[addr] = val;
    else if (addr == 6'd63) exp_swap = exp_swap | val;
    else exp_mode[addr - 6'd56] = val;
  endtask

  // read burst of n advances, aborted when n is below eight
  task automatic burst(input int n);
    logic [2:0] first;
    first = exp_swap ? `CML_REC_HALF : 3'h0;
    exp_swap = 1'b0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    for (int i = 0; i < n; i++) begin
      check_now(1'b1, first + 3'(i));
      adv = 1'b1;
      start = (i == 2); // a start while reading is ignored
      @(negedge core_clk);
      adv = 1'b0;
      start = 1'b0;
    end
    abort = (n < 8);
    @(negedge core_clk);
    abort = 1'b0;
    check_now(1'b0, 3'h0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==================================================
  // cycle ceiling against a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end

  // ==================================================
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    check_now(1'b0, 3'h0);
    for (int k = 0; k < 4; k++) begin
      put(k[0], 6'd48);
      put(k[1], 6'd49);
      check_now(1'b0, 3'h0);
    end
    for (int k = 40; k < 48; k++) put(1'b1, 6'(k));
    check_now(1'b0, 3'h0);
    put(1'b1, 6'd53);
    put(1'b1, 6'd50);
    check_now(1'b0, 3'h0);
    $display("config fields done");
    put(1'b1, 6'd56);
    put(1'b1, 6'd60);
    put(1'b1, 6'd58);
    check_now(1'b0, 3'h0);
    tamper = 1'b1;
    check_now(1'b0, 3'h0);
    put(1'b0, 6'd60);
    tamper = 1'b0;
    check_now(1'b0, 3'h0);
    $display("mode bits done");
    repeat (30) begin
      put(1'($random(seed)), 6'($random(seed)));
      check_now(1'b0, 3'h0);
    end
    ce = 1'b0;
    host_inst.send(~exp_cfg[0], 6'd0, 1'b0);
    ce = 1'b1;
    remote_reset = 1'b1;
    @(negedge core_clk);
    remote_reset = 1'b0;
    check_now(1'b0, 3'h0);
    $display("random and remote reset done");
    put(1'b1, 6'd63);
    burst(8);
    burst(8);
    put(1'b1, 6'd63);
    burst(3);
    $display("read bursts done");
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    exp_cfg = '0;
    exp_mode = '0;
    check_now(1'b0, 3'h0);
    $display("power-on reset done");
    conclude();
  end
endmodule
